/* File: hdl/lou_pkg.sv */
// Shared constants and types for the logical-or datapath slice
package lou_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned DATA_W   = 32;  // Datapath word width
   localparam int unsigned IMM_W    = 13;  // Short immediate width
   localparam int unsigned RIDX_W   = 5;   // Register index width
   localparam int unsigned RF_DEPTH = 32;  // Register file entries
   localparam int unsigned ADDR_W   = 8;   // Bus address width
   localparam int unsigned STRB_W   = 4;   // Byte strobes per word

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_INSTR   = 8'h00;  // Instruction, write starts execution
   localparam logic [7:0] OFS_STATUS  = 8'h04;  // Condition flags and state
   localparam logic [7:0] OFS_RF_IDX  = 8'h08;  // Register file window index
   localparam logic [7:0] OFS_RF_DATA = 8'h0c;  // Register file window data
   localparam logic [7:0] OFS_RESULT  = 8'h10;  // Last result, read only

   // ------------------------------------------------------------
   // Instruction register fields (low bit positions)
   // ------------------------------------------------------------
   localparam int unsigned POS_OP    = 0;   // Operation, 2 bits
   localparam int unsigned POS_ISEL  = 2;   // Immediate-select bit
   localparam int unsigned POS_DEST  = 3;   // Destination index, 5 bits
   localparam int unsigned POS_SRC_A = 8;   // First source index, 5 bits
   localparam int unsigned POS_SRC_B = 13;  // Second source index, 5 bits
   localparam int unsigned POS_IMM   = 18;  // Short immediate, 13 bits

   // ------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------
   localparam int unsigned POS_FLAG_C = 0;  // Carry
   localparam int unsigned POS_FLAG_V = 1;  // Overflow
   localparam int unsigned POS_FLAG_Z = 2;  // Zero
   localparam int unsigned POS_FLAG_N = 3;  // Negative
   localparam int unsigned POS_BUSY   = 4;  // Execution in progress

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_INSTR  = 32'h0000_0000;
   localparam logic [3:0]  RST_FLAGS  = 4'h0;
   localparam logic [4:0]  RST_RF_IDX = 5'h00;
   localparam logic [31:0] RST_RESULT = 32'h0000_0000;

   // ------------------------------------------------------------
   // Bus response codes
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Or-family operations, in field order
   typedef enum logic [1:0] {
      LOU_OP_OR,
      LOU_OP_ORCC,
      LOU_OP_ORN,
      LOU_OP_ORNCC
   } lou_op_t;

endpackage

/* File: hdl/lou_operand_sel.sv */
// Second operand select, sign extension and optional inversion
`timescale 1ns/1ps
module lou_operand_sel
   import lou_pkg::*;
(
   input  wire logic [lou_pkg::DATA_W-1:0] i_src_b,    // Second source register value
   input  wire logic                       i_imm_sel,  // 1 selects the short immediate
   input  wire logic [lou_pkg::IMM_W-1:0]  i_imm,      // Short immediate field
   input  wire logic                       i_invert,   // 1 for the inverted forms
   output logic      [lou_pkg::DATA_W-1:0] o_operand   // Operand handed to the OR
);

   // ------------------------------------------------------------
   // Operand formation
   // ------------------------------------------------------------
   logic [DATA_W-1:0] sel_val;  // Operand before inversion

   // Register or sign-extended immediate, then optional complement
   always_comb begin
      if (i_imm_sel) begin
         sel_val = {{(DATA_W-IMM_W){i_imm[IMM_W-1]}}, i_imm};
      end else begin
         sel_val = i_src_b;
      end
      o_operand = i_invert ? ~sel_val : sel_val;
   end

endmodule

/* File: hdl/lou_flag_gen.sv */
// Negative and zero flag derivation from a result word
`timescale 1ns/1ps
module lou_flag_gen
   import lou_pkg::*;
(
   input  wire logic [lou_pkg::DATA_W-1:0] i_result,  // Result word
   output logic                            o_neg,     // Top bit of result
   output logic                            o_zero     // Result is all zeros
);

   // ------------------------------------------------------------
   // Flag logic
   // ------------------------------------------------------------
   // Sign from the top bit, zero from a full-word compare
   always_comb begin
      o_neg  = i_result[DATA_W-1];
      o_zero = (i_result == '0);
   end

endmodule

/* File: hdl/lou_top.sv */
// Logical-or datapath slice with register file and AXI4-Lite slave
//
// Contract
// - Result is bitwise OR, full word
// - i=0 uses src B, i=1 sign-extended immediate
// - Result written to destination register
// - Inverted forms complement second operand first
// - Flag form: N from bit 31, Z
// - Inverted flag form: N, Z, clear V, C
`timescale 1ns/1ps
module lou_top
   import lou_pkg::*;
(
   input  wire logic                       i_mclk,     // Core clock, 100 MHz
   input  wire logic                       i_reset_n,  // Asynchronous reset, active low
   input  wire logic                       i_awvalid,  // Write address valid
   input  wire logic [lou_pkg::ADDR_W-1:0] i_awaddr,   // Write address
   output logic                            o_awready,  // Write address ready
   input  wire logic                       i_wvalid,   // Write data valid
   input  wire logic [lou_pkg::DATA_W-1:0] i_wdata,    // Write data
   input  wire logic [lou_pkg::STRB_W-1:0] i_wstrb,    // Write byte strobes
   output logic                            o_wready,   // Write data ready
   output logic                            o_bvalid,   // Write response valid
   output logic      [1:0]                 o_bresp,    // Write response code
   input  wire logic                       i_bready,   // Write response ready
   input  wire logic                       i_arvalid,  // Read address valid
   input  wire logic [lou_pkg::ADDR_W-1:0] i_araddr,   // Read address
   output logic                            o_arready,  // Read address ready
   output logic                            o_rvalid,   // Read data valid
   output logic      [lou_pkg::DATA_W-1:0] o_rdata,    // Read data
   output logic      [1:0]                 o_rresp,    // Read response code
   input  wire logic                       i_rready,   // Read data ready
   output logic      [3:0]                 o_flags,    // Condition flags N Z V C
   output logic                            o_exec_done // Pulse after a result is written
);

   // ------------------------------------------------------------
   // Write channel state
   // ------------------------------------------------------------
   logic              aw_held_r, aw_held_nxt;    // Address taken, awaiting response
   logic              w_held_r, w_held_nxt;      // Data taken, awaiting response
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;      // Captured write address
   logic [DATA_W-1:0] wdata_r, wdata_nxt;        // Captured write data
   logic [STRB_W-1:0] wstrb_r, wstrb_nxt;        // Captured byte strobes
   logic              awready_r, awready_nxt;    // Address ready flop
   logic              wready_r, wready_nxt;      // Data ready flop
   logic              bvalid_r, bvalid_nxt;      // Response valid flop
   logic [1:0]        bresp_r, bresp_nxt;        // Response code flop

   // ------------------------------------------------------------
   // Read channel state
   // ------------------------------------------------------------
   logic              arready_r, arready_nxt;    // Read address ready flop
   logic              rvalid_r, rvalid_nxt;      // Read data valid flop
   logic [DATA_W-1:0] rdata_r, rdata_nxt;        // Read data flop
   logic [1:0]        rresp_r, rresp_nxt;        // Read response flop

   // ------------------------------------------------------------
   // Block state
   // ------------------------------------------------------------
   logic [DATA_W-1:0] instr_r, instr_nxt;        // Instruction register
   logic              exec_r, exec_nxt;          // Execute in this cycle
   logic              done_r, done_nxt;          // Result written last cycle
   logic [3:0]        flags_r, flags_nxt;        // N Z V C
   logic [RIDX_W-1:0] rf_idx_r, rf_idx_nxt;      // Window index
   logic [DATA_W-1:0] result_r, result_nxt;      // Last result

   // Register file and its single write port
   logic [DATA_W-1:0] rf_mem [RF_DEPTH];         // General registers
   logic              rf_we;                     // Write enable
   logic [RIDX_W-1:0] rf_waddr;                  // Write index
   logic [DATA_W-1:0] rf_wdata;                  // Write value

   // ------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------
   lou_op_t           op;                        // Decoded operation
   logic              imm_sel;                   // Immediate-select bit
   logic [RIDX_W-1:0] dest_idx;                  // Destination index
   logic [RIDX_W-1:0] src_a_reg;                 // First source index
   logic [RIDX_W-1:0] src_b_reg;                 // Second source index
   logic [IMM_W-1:0]  short_imm_field;           // Short immediate
   logic              invert;                    // Inverted form
   logic              set_cc;                    // Flag-updating form
   logic [DATA_W-1:0] operand_b;                 // Selected second operand
   logic [DATA_W-1:0] or_result;                 // Datapath result
   logic              res_neg;                   // Negative from result
   logic              res_zero;                  // Zero from result

   // Field extraction from the instruction register
   always_comb begin
      op              = lou_op_t'(instr_r[POS_OP +: 2]);
      imm_sel         = instr_r[POS_ISEL];
      dest_idx        = instr_r[POS_DEST +: RIDX_W];
      src_a_reg       = instr_r[POS_SRC_A +: RIDX_W];
      src_b_reg       = instr_r[POS_SRC_B +: RIDX_W];
      short_imm_field = instr_r[POS_IMM +: IMM_W];
      invert          = (op == LOU_OP_ORN) || (op == LOU_OP_ORNCC);
      set_cc          = (op == LOU_OP_ORCC) || (op == LOU_OP_ORNCC);
   end

   // ------------------------------------------------------------
   // Datapath
   // ------------------------------------------------------------
   // Second operand: register or immediate, optionally complemented
   lou_operand_sel u_operand_sel (
      .i_src_b   (rf_mem[src_b_reg]),
      .i_imm_sel (imm_sel),
      .i_imm     (short_imm_field),
      .i_invert  (invert),
      .o_operand (operand_b)
   );

   assign or_result = rf_mem[src_a_reg] | operand_b;

   // Negative and zero from the result
   lou_flag_gen u_flag_gen (
      .i_result (or_result),
      .o_neg    (res_neg),
      .o_zero   (res_zero)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Merge write data into an old word under byte strobes
   function automatic logic [DATA_W-1:0] merge_bytes(
      input logic [DATA_W-1:0] old_val,
      input logic [DATA_W-1:0] new_val,
      input logic [STRB_W-1:0] strb
   );
      logic [DATA_W-1:0] res;
      res = old_val;
      for (int b = 0; b < STRB_W; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // Write channel and execution
   // ------------------------------------------------------------
   logic              aw_take;                   // Address handshake
   logic              w_take;                    // Data handshake
   logic              commit;                    // Apply the held write
   logic [DATA_W-1:0] wmerged;                   // Strobed write value

   assign aw_take = i_awvalid & awready_r;
   assign w_take  = i_wvalid & wready_r;
   assign commit  = aw_held_r & w_held_r & ~bvalid_r;

   // Next state for the write side, the instruction and the flags
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      instr_nxt   = instr_r;
      exec_nxt    = 1'b0;
      done_nxt    = exec_r;
      flags_nxt   = flags_r;
      rf_idx_nxt  = rf_idx_r;
      result_nxt  = result_r;
      rf_we       = 1'b0;
      rf_waddr    = rf_idx_r;
      rf_wdata    = '0;
      wmerged     = '0;
      // Capture address and data independently, in either order
      if (aw_take) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt  = i_awaddr;
      end
      if (w_take) begin
         w_held_nxt = 1'b1;
         wdata_nxt  = i_wdata;
         wstrb_nxt  = i_wstrb;
      end
      // Both halves present: decode and apply, then respond
      if (commit) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = RESP_OKAY;
         if (awaddr_r == OFS_INSTR) begin
            // Instruction write starts execution next cycle
            instr_nxt = merge_bytes(instr_r, wdata_r, wstrb_r);
            exec_nxt  = 1'b1;
         end else if (awaddr_r == OFS_STATUS) begin
            // Software may preset the flags
            if (wstrb_r[0]) begin
               flags_nxt = wdata_r[POS_FLAG_C +: 4];
            end
         end else if (awaddr_r == OFS_RF_IDX) begin
            // Window index
            if (wstrb_r[0]) begin
               rf_idx_nxt = wdata_r[RIDX_W-1:0];
            end
         end else if (awaddr_r == OFS_RF_DATA) begin
            // Window data goes to the indexed register
            wmerged  = merge_bytes(rf_mem[rf_idx_r], wdata_r, wstrb_r);
            rf_we    = 1'b1;
            rf_waddr = rf_idx_r;
            rf_wdata = wmerged;
         end else if (awaddr_r == OFS_RESULT) begin
            // Read-only register, write ignored
            bresp_nxt = RESP_OKAY;
         end else begin
            // Unmapped address
            bresp_nxt = RESP_DECERR;
         end
      end
      // Response taken: free both channels
      if (bvalid_r && i_bready) begin
         bvalid_nxt  = 1'b0;
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
      end
      // Execution cycle; no write commit can fall here
      if (exec_r) begin
         rf_we      = 1'b1;
         rf_waddr   = dest_idx;
         rf_wdata   = or_result;
         result_nxt = or_result;
         if (set_cc) begin
            // N Z set, V C cleared
            flags_nxt[POS_FLAG_N] = res_neg;
            flags_nxt[POS_FLAG_Z] = res_zero;
            flags_nxt[POS_FLAG_V] = 1'b0;
            flags_nxt[POS_FLAG_C] = 1'b0;
         end
      end
      awready_nxt = ~aw_held_nxt;
      wready_nxt  = ~w_held_nxt;
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   logic ar_take;                                // Read address handshake

   assign ar_take = i_arvalid & arready_r;

   // Decode read address into data and response
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (rvalid_r && i_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (ar_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         rdata_nxt  = '0;
         if (i_araddr == OFS_INSTR) begin
            rdata_nxt = instr_r;
         end else if (i_araddr == OFS_STATUS) begin
            rdata_nxt[POS_FLAG_C +: 4] = flags_r;
            rdata_nxt[POS_BUSY]        = exec_r;
         end else if (i_araddr == OFS_RF_IDX) begin
            rdata_nxt[RIDX_W-1:0] = rf_idx_r;
         end else if (i_araddr == OFS_RF_DATA) begin
            rdata_nxt = rf_mem[rf_idx_r];
         end else if (i_araddr == OFS_RESULT) begin
            rdata_nxt = result_r;
         end else begin
            rresp_nxt = RESP_DECERR;
         end
      end
      arready_nxt = ~rvalid_nxt;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Control and bus state
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
         instr_r   <= RST_INSTR;
         exec_r    <= 1'b0;
         done_r    <= 1'b0;
         flags_r   <= RST_FLAGS;
         rf_idx_r  <= RST_RF_IDX;
         result_r  <= RST_RESULT;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
         instr_r   <= instr_nxt;
         exec_r    <= exec_nxt;
         done_r    <= done_nxt;
         flags_r   <= flags_nxt;
         rf_idx_r  <= rf_idx_nxt;
         result_r  <= result_nxt;
      end
   end

   // Register file storage, no reset
   always_ff @(posedge i_mclk) begin
      if (rf_we) begin
         rf_mem[rf_waddr] <= rf_wdata;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_awready   = awready_r;
   assign o_wready    = wready_r;
   assign o_bvalid    = bvalid_r;
   assign o_bresp     = bresp_r;
   assign o_arready   = arready_r;
   assign o_rvalid    = rvalid_r;
   assign o_rdata     = rdata_r;
   assign o_rresp     = rresp_r;
   assign o_flags     = flags_r;
   assign o_exec_done = done_r;

endmodule

/* File: tb/lou_props.sv */
// Port-level checks on the logical-or slice
`timescale 1ns/1ps
module lou_props
   import lou_pkg::*;
(
   input  wire logic                       i_mclk,
   input  wire logic                       i_reset_n,
   input  wire logic                       i_awvalid,
   input  wire logic                       o_awready,
   input  wire logic                       i_wvalid,
   input  wire logic                       o_wready,
   input  wire logic                       o_bvalid,
   input  wire logic [1:0]                 o_bresp,
   input  wire logic                       i_bready,
   input  wire logic                       i_arvalid,
   input  wire logic                       o_arready,
   input  wire logic                       o_rvalid,
   input  wire logic [lou_pkg::DATA_W-1:0] o_rdata,
   input  wire logic                       i_rready,
   input  wire logic [3:0]                 o_flags,
   input  wire logic                       o_exec_done
);
   default clocking dck @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   // Answers stand until taken
   b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped early");
   r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped early");
   // Answer latencies
   w_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
      else $error("write answer not on time");
   r_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer not on time");
   w_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while one outstanding");
   done_pulse_a: assert property (o_exec_done |=> !o_exec_done)
      else $error("done pulse too long");
   // Flags move only on execution or a status write
   flag_cause_a: assert property ($changed(o_flags) |-> o_exec_done || $rose(o_bvalid))
      else $error("flags changed without cause");
   cc_clear_a: assert property (o_exec_done && $changed(o_flags) |-> o_flags[1:0] == 2'h0)
      else $error("overflow or carry left set");
   zero_neg_a: assert property (o_exec_done && $changed(o_flags) && o_flags[2] |-> !o_flags[3])
      else $error("zero and negative both set");
endmodule

bind lou_top lou_props i_props (
   .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
   .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
   .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
   .o_rdata(o_rdata), .i_rready(i_rready), .o_flags(o_flags), .o_exec_done(o_exec_done)
);

/* File: tb/lou_mst.sv */
// Bus master model standing in for the decode side
`timescale 1ns/1ps
module lou_mst (
   input  wire logic        i_clk,
   input  wire logic        i_awready,
   input  wire logic        i_wready,
   input  wire logic        i_bvalid,
   input  wire logic [1:0]  i_bresp,
   input  wire logic        i_arready,
   input  wire logic        i_rvalid,
   input  wire logic [31:0] i_rdata,
   input  wire logic [1:0]  i_rresp,
   output logic             o_awvalid = 1'b0,
   output logic      [7:0]  o_awaddr = 8'h00,
   output logic             o_wvalid = 1'b0,
   output logic      [31:0] o_wdata = 32'h0,
   output logic      [3:0]  o_wstrb = 4'h0,
   output logic             o_bready = 1'b0,
   output logic             o_arvalid = 1'b0,
   output logic      [7:0]  o_araddr = 8'h00,
   output logic             o_rready = 1'b0
);
   // Full-word write; each channel dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta = 1'b0;
      logic tw = 1'b0;
      logic h;
      o_awaddr <= a;
      o_wdata <= d;
      o_wstrb <= 4'hf;
      o_awvalid <= 1'b1;
      o_wvalid <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge i_clk);
         h = !ta && i_awready;
         tw = tw || i_wready;
         ta = ta || h;
         @(posedge i_clk);
         if (ta) o_awvalid <= 1'b0;
         if (tw) o_wvalid <= 1'b0;
      end
      // Response ready raised two cycles after the handshake, one cycle after the answer, so the write answer must stand one cycle
      repeat (2) @(posedge i_clk);
      o_bready <= 1'b1;
      do begin
         @(negedge i_clk);
         h = i_bvalid;
         r = i_bresp;
         @(posedge i_clk);
      end while (!h);
      o_bready <= 1'b0;
   endtask

   // Single-word read
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic h;
      o_araddr <= a;
      o_arvalid <= 1'b1;
      do begin
         @(negedge i_clk);
         h = i_arready;
         @(posedge i_clk);
      end while (!h);
      o_arvalid <= 1'b0;
      // Late data ready, so the read answer must stand one cycle
      @(posedge i_clk);
      o_rready <= 1'b1;
      do begin
         @(negedge i_clk);
         h = i_rvalid;
         d = i_rdata;
         r = i_rresp;
         @(posedge i_clk);
      end while (!h);
      o_rready <= 1'b0;
   endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the logical-or slice
`timescale 1ns/1ps
module tb_top;
   import lou_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_done = 0;
   wire logic awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, done;
   wire logic [7:0] awa, ara;
   wire logic [31:0] wd, rdat;
   wire logic [3:0] strb, flags;
   wire logic [1:0] bresp, rresp;

   always #5 mclk = ~mclk;

   lou_top i_dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_awvalid(awv), .i_awaddr(awa),
      .o_awready(awr), .i_wvalid(wv), .i_wdata(wd), .i_wstrb(strb), .o_wready(wr_),
      .o_bvalid(bv), .o_bresp(bresp), .i_bready(br), .i_arvalid(arv), .i_araddr(ara),
      .o_arready(arr), .o_rvalid(rv), .o_rdata(rdat), .o_rresp(rresp), .i_rready(rr),
      .o_flags(flags), .o_exec_done(done));
   lou_mst i_mst (.i_clk(mclk), .i_awready(awr), .i_wready(wr_), .i_bvalid(bv),
      .i_bresp(bresp), .i_arready(arr), .i_rvalid(rv), .i_rdata(rdat), .i_rresp(rresp),
      .o_awvalid(awv), .o_awaddr(awa), .o_wvalid(wv), .o_wdata(wd), .o_wstrb(strb),
      .o_bready(br), .o_arvalid(arv), .o_araddr(ara), .o_rready(rr));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      i_mst.rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      i_mst.wr(a, d, r);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // Completion pulses seen
   always @(negedge mclk) if (done === 1'b1) n_done++;

   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         wrap_up;
      end
   end

   initial begin
      logic [31:0] ra [2] = '{32'h8000_0f00, 32'h0000_0000};
      logic [31:0] rb [2] = '{32'h0000_00f0, 32'hffff_ffff};
      logic [12:0] im [2] = '{13'h1abc, 13'h0000};
      logic [31:0] op2;
      logic [31:0] res;
      logic [3:0] fl;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      rdc(OFS_INSTR, 32'h0, RESP_OKAY);
      rdc(OFS_STATUS, 32'h0, RESP_OKAY);
      rdc(OFS_RESULT, 32'h0, RESP_OKAY);
      wrc(8'h14, 32'h1, RESP_DECERR);
      rdc(8'h14, 32'h0, RESP_DECERR);
      wrc(OFS_RESULT, 32'h5, RESP_OKAY);
      rdc(OFS_RESULT, 32'h0, RESP_OKAY);
      // Every form, register and immediate operand, two operand sets
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 8; k++) begin
            wrc(OFS_RF_IDX, 32'h1, RESP_OKAY);
            wrc(OFS_RF_DATA, ra[s], RESP_OKAY);
            wrc(OFS_RF_IDX, 32'h2, RESP_OKAY);
            wrc(OFS_RF_DATA, rb[s], RESP_OKAY);
            wrc(OFS_STATUS, 32'h3, RESP_OKAY);
            op2 = k[2] ? {{19{im[s][12]}}, im[s]} : rb[s];
            if (k[1]) op2 = ~op2;
            res = ra[s] | op2;
            fl = k[0] ? {res[31], res == 32'h0, 2'h0} : 4'h3;
            wrc(OFS_INSTR, {1'b0, im[s], 5'h02, 5'h01, 5'h03, k[2], k[1:0]}, RESP_OKAY);
            rdc(OFS_RESULT, res, RESP_OKAY);
            wrc(OFS_RF_IDX, 32'h3, RESP_OKAY);
            rdc(OFS_RF_DATA, res, RESP_OKAY);
            chk({28'h0, flags}, {28'h0, fl});
            rdc(OFS_STATUS, {28'h0, fl}, RESP_OKAY);
         end
      end
      chk(n_done, 32'h10);
      wrap_up;
   end
endmodule
